// [hdl/pin_func_map.svh]
`ifndef PIN_FUNC_MAP_SVH
`define PIN_FUNC_MAP_SVH

// Function select codes held in nonvolatile configuration
`define FUNC_FLOAT        5'h00
`define FUNC_DRIVE_HIGH   5'h01
`define FUNC_DRIVE_LOW    5'h02
`define FUNC_LINE_DRIVER  5'h03
`define FUNC_POWER_SWITCH 5'h04
`define FUNC_UP_LED       5'h05
`define FUNC_DOWN_LED     5'h06
`define FUNC_ANY_LED      5'h07
`define FUNC_SLEEP        5'h08
`define FUNC_CLK_FAST     5'h09
`define FUNC_CLK_MID      5'h0A
`define FUNC_CLK_SLOW     5'h0B
`define FUNC_GPIO         5'h0C
`define FUNC_CHARGER      5'h0D
`define FUNC_CHARGER_INV  5'h0E
`define FUNC_WRITE_STROBE 5'h0F
`define FUNC_READ_STROBE  5'h10
`define FUNC_VBUS_SENSE   5'h11
`define FUNC_FRAME_TOGGLE 5'h12
`define FUNC_STAY_AWAKE   5'h13
`define FUNC_RESET_VALUE  5'h03

// LED stretch: least visible pulse in microseconds
`define LED_MIN_US        10
`define CLK_MHZ           40
`define LED_STRETCH_CYC   (`LED_MIN_US * `CLK_MHZ)

`endif

// [hdl/pin_func_pkg.sv]
package pin_func_pkg;
  typedef logic [4:0] func_sel_t;
  typedef logic [3:0] port_data_t;
  typedef enum logic [1:0] {PORT_UART, PORT_ASYNC, PORT_SYNC} port_mode_t;
endpackage

// [hdl/led_stretch.sv]
`timescale 1ns/100ps
`include "pin_func_map.svh"

module led_stretch (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic activity,
  output logic      led_n
);
  logic [15:0] count_reg;

  // Reload on every activity so bursts stay lit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
    end else if (activity) begin
      count_reg <= 16'(`LED_STRETCH_CYC);
    end else if (count_reg != 16'h0000) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_n <= 1'b1;
    end else begin
      led_n <= !(activity || count_reg > 16'h0001);
    end
  end
endmodule

// [hdl/config_pin_function_select.sv]
`timescale 1ns/100ps
`include "pin_func_map.svh"

module config_pin_function_select
  import pin_func_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     cfg_valid,
  input  wire pin_func_pkg::func_sel_t  cfg_func,
  input  wire logic                     cfg_pull_down_suspend,
  input  wire pin_func_pkg::port_mode_t port_mode,
  input  wire logic                     usb_configured,
  input  wire logic                     usb_suspend,
  input  wire logic                     usb_sof,
  input  wire logic                     charger_port_detect,
  input  wire logic                     serial_tx_busy,
  input  wire logic                     uplink_activity,
  input  wire logic                     downlink_activity,
  input  wire logic                     clk_24_en,
  input  wire logic                     clk_12_en,
  input  wire logic                     clk_6_en,
  input  wire logic                     gpio_out,
  input  wire logic                     gpio_oe,
  input  wire logic [15:0]              pace_divisor,
  input  wire logic                     port_write,
  input  wire pin_func_pkg::port_data_t port_write_data,
  output logic                          port_write_ready,
  input  wire logic                     port_read_req,
  output pin_func_pkg::port_data_t      port_read_data,
  output logic                          port_read_valid,
  input  wire pin_func_pkg::port_data_t port_pin_in,
  output pin_func_pkg::port_data_t      port_pin_out,
  output pin_func_pkg::port_data_t      port_pin_oe,
  output logic                          bitbang_active,
  input  wire logic                     config_pin_in,
  output logic                          config_pin_out,
  output logic                          config_pin_oe,
  output logic                          input_pull_down,
  output logic                          gpio_in,
  output logic                          vbus_present,
  output logic                          stay_awake
);
  import pin_func_pkg::*;

  func_sel_t   func_reg;
  logic        pin_out_next;
  logic        pin_oe_next;
  logic        frame_toggle_reg;
  logic        clk_div_reg;
  logic        write_strobe_n_reg;
  logic        read_strobe_n_reg;
  logic        pace_busy_reg;
  logic [15:0] pace_count_reg;
  port_data_t  port_out_reg;
  logic        rate_en;
  logic        clk_mode;
  logic        port_accept;
  logic        sync_write;
  logic        pace_start;
  logic        port_sample;
  logic [2:0]  led_activity;
  logic [2:0]  led_n;
  logic        up_led_n;
  logic        down_led_n;
  logic        any_led_n;

  // Configuration loaded on every cfg_valid; function held between loads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_reg <= `FUNC_RESET_VALUE;
    end else if (cfg_valid) begin
      func_reg <= cfg_func;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_toggle_reg <= 1'b0;
    end else if (usb_sof) begin
      frame_toggle_reg <= !frame_toggle_reg;
    end
  end

  // Rate enable of the chosen clock option
  assign clk_mode = (func_reg == `FUNC_CLK_FAST) || (func_reg == `FUNC_CLK_MID) ||
                    (func_reg == `FUNC_CLK_SLOW);

  always_comb begin
    rate_en = 1'b0;
    case (func_reg)
      `FUNC_CLK_FAST: rate_en = clk_24_en;
      `FUNC_CLK_MID:  rate_en = clk_12_en;
      `FUNC_CLK_SLOW: rate_en = clk_6_en;
      default:        rate_en = 1'b0;
    endcase
  end

  // Held low in suspend and in other functions so no runt edge escapes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_div_reg <= 1'b0;
    end else if (usb_suspend || !clk_mode) begin
      clk_div_reg <= 1'b0;
    end else begin
      clk_div_reg <= clk_div_reg ^ rate_en;
    end
  end

  // One stretcher per LED flavour: uplink, downlink, either
  assign led_activity[0] = uplink_activity;
  assign led_activity[1] = downlink_activity;
  assign led_activity[2] = uplink_activity || downlink_activity;

  generate
    for (genvar g = 0; g < 3; g++) begin : gen_led
      led_stretch stretch (
        .clk      (clk),
        .rst_n    (rst_n),
        .activity (led_activity[g]),
        .led_n    (led_n[g])
      );
    end
  endgenerate

  assign up_led_n   = led_n[0];
  assign down_led_n = led_n[1];
  assign any_led_n  = led_n[2];

  assign bitbang_active = (port_mode != PORT_UART);
  assign port_accept    = port_write && port_write_ready;
  assign sync_write     = (port_mode == PORT_SYNC) && port_write;
  assign pace_start     = (port_mode == PORT_ASYNC) && port_accept;
  assign port_sample    = sync_write || ((port_mode == PORT_ASYNC) && port_read_req);

  // Async pacing timer; a write waits for the previous byte's slot
  assign port_write_ready = !(port_mode == PORT_ASYNC && pace_busy_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_busy_reg <= 1'b0;
    end else if (pace_start) begin
      pace_busy_reg <= 1'b1;
    end else if (pace_count_reg == 16'h0000) begin
      pace_busy_reg <= 1'b0;
    end
  end

  // Counts the slot down; a zero divisor still costs one busy cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_count_reg <= 16'h0000;
    end else if (pace_start) begin
      pace_count_reg <= pace_divisor;
    end else if (pace_count_reg != 16'h0000) begin
      pace_count_reg <= pace_count_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_out_reg <= 4'h0;
    end else if (bitbang_active && port_accept) begin
      port_out_reg <= port_write_data;
    end
  end

  assign port_pin_out = port_out_reg;
  assign port_pin_oe  = bitbang_active ? 4'hF : 4'h0;

  // Sync mode samples pins with each write; async samples on read request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_read_data <= 4'h0;
    end else if (port_sample) begin
      port_read_data <= port_pin_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_read_valid <= 1'b0;
    end else begin
      port_read_valid <= port_sample;
    end
  end

  // Registered strobes keep decode glitches off external clock inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_strobe_n_reg <= 1'b1;
    end else begin
      write_strobe_n_reg <= !(bitbang_active && port_accept);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n_reg <= 1'b1;
    end else begin
      read_strobe_n_reg <= !(bitbang_active && (port_read_req || sync_write));
    end
  end

  always_comb begin
    pin_oe_next  = 1'b1;
    pin_out_next = 1'b0;
    case (func_reg)
      `FUNC_FLOAT:        pin_oe_next = 1'b0;
      `FUNC_DRIVE_HIGH:   pin_out_next = 1'b1;
      `FUNC_DRIVE_LOW:    pin_out_next = 1'b0;
      `FUNC_LINE_DRIVER:  pin_out_next = serial_tx_busy;
      `FUNC_POWER_SWITCH: pin_out_next = usb_suspend || !usb_configured;
      `FUNC_UP_LED:       pin_out_next = up_led_n;
      `FUNC_DOWN_LED:     pin_out_next = down_led_n;
      `FUNC_ANY_LED:      pin_out_next = any_led_n;
      `FUNC_SLEEP:        pin_out_next = !usb_suspend;
      `FUNC_CLK_FAST,
      `FUNC_CLK_MID,
      `FUNC_CLK_SLOW:     pin_out_next = clk_div_reg;
      `FUNC_GPIO: begin
        pin_out_next = gpio_out;
        pin_oe_next  = gpio_oe;
      end
      `FUNC_CHARGER:      pin_out_next = charger_port_detect;
      `FUNC_CHARGER_INV:  pin_out_next = !charger_port_detect;
      `FUNC_WRITE_STROBE: pin_out_next = write_strobe_n_reg;
      `FUNC_READ_STROBE:  pin_out_next = read_strobe_n_reg;
      `FUNC_VBUS_SENSE,
      `FUNC_STAY_AWAKE:   pin_oe_next = 1'b0;
      `FUNC_FRAME_TOGGLE: pin_out_next = frame_toggle_reg;
      default:            pin_oe_next = 1'b0;
    endcase
  end

  // Pin registered to keep glitches off external switches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_pin_out <= 1'b0;
    end else begin
      config_pin_out <= pin_out_next;
    end
  end

  // Reset leaves the pin floating until the function is known
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_pin_oe <= 1'b0;
    end else begin
      config_pin_oe <= pin_oe_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_in <= 1'b0;
    end else begin
      gpio_in <= (func_reg == `FUNC_GPIO) && config_pin_in;
    end
  end

  // Present unless sensing, so a fixed pin never fakes an unplug
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_present <= 1'b1;
    end else begin
      vbus_present <= (func_reg != `FUNC_VBUS_SENSE) || config_pin_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stay_awake <= 1'b0;
    end else begin
      stay_awake <= (func_reg == `FUNC_STAY_AWAKE) && !config_pin_in;
    end
  end

  // Registered like the other levels; pulls only matter in suspend
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_pull_down <= 1'b0;
    end else begin
      input_pull_down <= cfg_pull_down_suspend && usb_suspend;
    end
  end
endmodule

// [test/cfg_pin_chk.sv]
`timescale 1ns/100ps
`include "pin_func_map.svh"

module cfg_pin_chk (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     cfg_valid,
  input wire pin_func_pkg::func_sel_t  cfg_func,
  input wire logic                     usb_suspend,
  input wire logic                     usb_configured,
  input wire logic                     usb_sof,
  input wire logic                     serial_tx_busy,
  input wire logic                     uplink_activity,
  input wire logic                     downlink_activity,
  input wire pin_func_pkg::port_mode_t port_mode,
  input wire logic                     port_write,
  input wire logic                     port_write_ready,
  input wire pin_func_pkg::port_data_t port_pin_in,
  input wire pin_func_pkg::port_data_t port_read_data,
  input wire logic                     port_read_valid,
  input wire logic                     bitbang_active,
  input wire pin_func_pkg::port_data_t port_pin_oe,
  input wire pin_func_pkg::port_data_t port_pin_out,
  input wire pin_func_pkg::port_data_t port_write_data,
  input wire logic                     config_pin_out,
  input wire logic                     config_pin_oe
);
  import pin_func_pkg::*;
  func_sel_t mode_reg;
  // Shadow of the function register, same one-edge load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mode_reg <= `FUNC_RESET_VALUE;
    else if (cfg_valid)
      mode_reg <= cfg_func;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence led_low_s;
    !config_pin_out [*8];
  endsequence
  sequence toggled_s;
    ##2 (config_pin_out != $past(config_pin_out));
  endsequence
  AST_FIXED_HIGH: assert property (mode_reg == `FUNC_DRIVE_HIGH |=>
    config_pin_oe && config_pin_out)
    else $error("fixed high level lost");
  AST_LINE_DRV: assert property (mode_reg == `FUNC_LINE_DRIVER |=>
    config_pin_oe && config_pin_out == $past(serial_tx_busy))
    else $error("line driver enable wrong");
  AST_POWER: assert property (mode_reg == `FUNC_POWER_SWITCH |=>
    config_pin_out == ($past(usb_suspend) || !$past(usb_configured)))
    else $error("power switch level wrong");
  AST_FRAME: assert property (mode_reg == `FUNC_FRAME_TOGGLE && usb_sof && !cfg_valid
    |-> toggled_s)
    else $error("frame toggle missing");
  AST_LED: assert property (mode_reg == `FUNC_ANY_LED &&
    (uplink_activity || downlink_activity) && !cfg_valid |-> ##[1:2] led_low_s)
    else $error("activity led not low");
  AST_BB_OE: assert property (bitbang_active == (port_mode != PORT_UART) &&
    (!bitbang_active || port_pin_oe == 4'hF))
    else $error("bit-bang port not driven");
  AST_PORT_OUT: assert property (bitbang_active && port_write && port_write_ready
    |=> port_pin_out == $past(port_write_data))
    else $error("bit-bang output not written");
  AST_SYNC_RD: assert property (port_mode == PORT_SYNC && port_write &&
    port_write_ready |=> port_read_valid && port_read_data == $past(port_pin_in))
    else $error("sync sample wrong");
  AST_PACE: assert property (port_mode == PORT_ASYNC && port_write && port_write_ready
    |=> !port_write_ready)
    else $error("pace timer not started");
endmodule

bind config_pin_function_select cfg_pin_chk chk (.clk, .rst_n, .cfg_valid, .cfg_func, .usb_suspend,
  .usb_configured, .usb_sof, .serial_tx_busy, .uplink_activity, .downlink_activity, .port_mode,
  .port_write, .port_write_ready, .port_pin_in, .port_read_data, .port_read_valid, .bitbang_active,
  .port_pin_oe, .config_pin_out, .config_pin_oe, .port_pin_out, .port_write_data);

// [test/pin_partner.sv]
`timescale 1ns/100ps

module pin_partner (
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pin_level
);
  // Pull-up wins when nobody drives; device drive wins over external logic
  assign pin_level = pin_oe ? pin_out : (ext_en ? ext_val : 1'h1);
endmodule

// [test/test_config_pin_function_select.sv]
`timescale 1ns/100ps
`include "pin_func_map.svh"

module test_config_pin_function_select;
  import pin_func_pkg::*;
  logic clk, rst_n, cfg_valid, cfg_pull_down_suspend, usb_configured, usb_suspend, usb_sof;
  logic charger_port_detect, serial_tx_busy, uplink_activity, downlink_activity, gpio_out;
  logic clk_24_en, clk_12_en, clk_6_en, gpio_oe, port_write, port_read_req, ext_en, ext_val;
  logic port_write_ready, port_read_valid, bitbang_active, config_pin_in, config_pin_out;
  logic config_pin_oe, input_pull_down, gpio_in, vbus_present, stay_awake, saved;
  func_sel_t   cfg_func;
  port_mode_t  port_mode;
  port_data_t  port_write_data, port_read_data, port_pin_in, port_pin_out, port_pin_oe;
  logic [15:0] pace_divisor, lows;
  int          mismatches, num_checks, i;

  config_pin_function_select uut (.clk, .rst_n, .cfg_valid, .cfg_func, .cfg_pull_down_suspend,
    .port_mode, .usb_configured, .usb_suspend, .usb_sof, .charger_port_detect, .serial_tx_busy,
    .uplink_activity, .downlink_activity, .clk_24_en, .clk_12_en, .clk_6_en, .gpio_out, .gpio_oe,
    .pace_divisor, .port_write, .port_write_data, .port_write_ready, .port_read_req,
    .port_read_data, .port_read_valid, .port_pin_in, .port_pin_out, .port_pin_oe, .bitbang_active,
    .config_pin_in, .config_pin_out, .config_pin_oe, .input_pull_down, .gpio_in, .vbus_present,
    .stay_awake);
  pin_partner peer (.pin_out(config_pin_out), .pin_oe(config_pin_oe), .ext_en, .ext_val,
    .pin_level(config_pin_in));

  always #12.5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic set_func(input func_sel_t f);
    cfg_func = f;
    cfg_valid = 1'h1;
    tick(1);
    cfg_valid = 1'h0;
    tick(3);
  endtask
  task automatic port_wr(input port_data_t d);
    port_write_data = d;
    port_write = 1'h1;
    tick(1);
    port_write = 1'h0;
  endtask
  // Strobe may land one edge late on the pin, so count over a window
  task automatic strobe_chk;
    lows = 16'h0;
    repeat (4) begin
      lows += !config_pin_out;
      tick(1);
    end
    check(lows, 16'h1);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {clk, rst_n, cfg_valid, cfg_pull_down_suspend, usb_suspend, usb_sof, charger_port_detect,
      serial_tx_busy, uplink_activity, downlink_activity, gpio_out, gpio_oe, port_write,
      port_read_req, ext_en, ext_val} = '0;
    {usb_configured, clk_24_en, clk_12_en, clk_6_en} = 4'hF;
    cfg_func = `FUNC_FLOAT;
    port_mode = PORT_UART;
    pace_divisor = 16'h0003;
    port_write_data = 4'h0;
    port_pin_in = 4'hA;
    tick(8);
    rst_n = 1'h1;
    serial_tx_busy = 1'h1;
    tick(2);
    check({config_pin_oe, config_pin_out}, 16'h3);
    serial_tx_busy = 1'h0;
    tick(1);
    check(config_pin_out, 16'h0);
    for (i = 0; i < 3; i++) begin
      set_func(i[4:0]);
      check(config_pin_oe, i != 0);
      if (i != 0) check(config_pin_out, i == 1);
    end
    set_func(5'h15);
    check(config_pin_oe, 16'h0);
    $display("fixed levels done");
    set_func(`FUNC_POWER_SWITCH);
    check(config_pin_out, 16'h0);
    usb_suspend = 1'h1;
    tick(1);
    check(config_pin_out, 16'h1);
    set_func(`FUNC_SLEEP);
    check(config_pin_out, 16'h0);
    usb_suspend = 1'h0;
    tick(1);
    check(config_pin_out, 16'h1);
    charger_port_detect = 1'h1;
    set_func(`FUNC_CHARGER);
    check(config_pin_out, 16'h1);
    set_func(`FUNC_CHARGER_INV);
    check(config_pin_out, 16'h0);
    $display("status outputs done");
    for (i = 9; i < 12; i++) begin
      {clk_24_en, clk_12_en, clk_6_en} = 3'h4 >> (i - 9);
      set_func(i[4:0]);
      saved = config_pin_out;
      tick(1);
      check(config_pin_out, !saved);
    end
    cfg_pull_down_suspend = 1'h1;
    usb_suspend = 1'h1;
    tick(2);
    check({config_pin_out, input_pull_down}, 16'h1);
    tick(1);
    check(config_pin_out, 16'h0);
    usb_suspend = 1'h0;
    $display("clock outputs done");
    {gpio_oe, gpio_out} = 2'h3;
    set_func(`FUNC_GPIO);
    check({config_pin_oe, config_pin_out, input_pull_down}, 16'h6);
    {gpio_oe, ext_en, ext_val} = 3'h2;
    tick(2);
    check({config_pin_oe, gpio_in}, 16'h0);
    ext_val = 1'h1;
    tick(2);
    check(gpio_in, 16'h1);
    ext_val = 1'h0;
    set_func(`FUNC_VBUS_SENSE);
    check({config_pin_oe, vbus_present}, 16'h0);
    ext_val = 1'h1;
    set_func(`FUNC_STAY_AWAKE);
    check({vbus_present, stay_awake}, 16'h2);
    ext_val = 1'h0;
    tick(2);
    check(stay_awake, 16'h1);
    ext_en = 1'h0;
    $display("input modes done");
    for (i = 5; i < 8; i++) begin
      set_func(i[4:0]);
      check(config_pin_out, 16'h1);
      if (i == 6) downlink_activity = 1'h1;
      else uplink_activity = 1'h1;
      tick(1);
      {uplink_activity, downlink_activity} = 2'h0;
      tick(3);
      check(config_pin_out, 16'h0);
      tick(300);
      check(config_pin_out, 16'h0);
      tick(150);
      check(config_pin_out, 16'h1);
    end
    set_func(`FUNC_FRAME_TOGGLE);
    repeat (2) begin
      saved = config_pin_out;
      usb_sof = 1'h1;
      tick(1);
      usb_sof = 1'h0;
      tick(2);
      check(config_pin_out, !saved);
    end
    $display("led and frame done");
    port_mode = PORT_SYNC;
    set_func(`FUNC_WRITE_STROBE);
    check({bitbang_active, port_pin_oe}, 16'h1F);
    port_wr(4'h6);
    check({port_pin_out, port_read_valid, port_read_data}, 16'h0DA);
    strobe_chk();
    set_func(`FUNC_READ_STROBE);
    port_wr(4'h9);
    strobe_chk();
    port_mode = PORT_ASYNC;
    tick(1);
    port_wr(4'h3);
    check(port_write_ready, 16'h0);
    for (i = 0; i < 40 && port_write_ready !== 1'h1; i++) tick(1);
    if (i == 40) mismatches++;
    check(i >= 3 && i <= 5, 16'h1);
    port_pin_in = 4'h5;
    port_read_req = 1'h1;
    tick(1);
    port_read_req = 1'h0;
    check({port_read_valid, port_read_data}, 16'h15);
    strobe_chk();
    port_mode = PORT_UART;
    tick(1);
    check(bitbang_active, 16'h0);
    $display("bit-bang done");
    final_report();
  end
endmodule
